// ===== icu_top.sv
// Implementation choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`include "icu_consts.svh"

// ==========================================================
// input change interrupt unit, wishbone classic slave
// ==========================================================
module icu_top #(
    parameter int NBITS = `ICU_NBITS,
    parameter int CLK_KHZ = `ICU_CLK_KHZ,
    parameter int FILT_BASE_KHZ = `ICU_FILT_BASE_KHZ
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [`ICU_ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [NBITS-1:0] din_i,
    output logic irq_o
);
    localparam int LIM_W = `ICU_LIMIT_W;

    // ==========================================================
    // declarations
    // ==========================================================
    logic [NBITS-1:0] din_s1;
    logic [NBITS-1:0] din_s2;
    icu_pkg::icu_vec_t enable;
    icu_pkg::icu_vec_t edge_fall;
    icu_pkg::icu_filt_t filt_set;
    icu_pkg::icu_limit_t limit;
    logic wb_hit;
    logic wb_wr;
    logic wb_rd;
    logic [`ICU_ADR_W-1:0] wb_off;
    icu_pkg::icu_vec_t clr_vec;
    icu_pkg::icu_word_t next_dat;
    icu_pkg::icu_limit_t next_limit;

    icu_evt_if #(.W(NBITS)) evt ();

    // ==========================================================
    // byte lane merge
    // ==========================================================
    function automatic icu_pkg::icu_word_t icu_merge(
        input icu_pkg::icu_word_t old_v,
        input icu_pkg::icu_word_t new_v,
        input logic [3:0] sel
    );
        icu_pkg::icu_word_t r;
        integer b;
        r = old_v;
        for (b = 0; b < 4; b = b + 1) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ==========================================================
    // filter length from the setting
    // ==========================================================
    // cycles = ceil(2^n * clk / base); 64-bit math since 2^20 * 50000 overflows 32 bits
    function automatic icu_pkg::icu_limit_t icu_calc_limit(
        input icu_pkg::icu_filt_t n
    );
        logic [63:0] num;
        logic [63:0] q;
        num = (64'h1 << n) * 64'(CLK_KHZ);
        q = (num + 64'(FILT_BASE_KHZ) - 64'h1) / 64'(FILT_BASE_KHZ);
        if (q == 64'h0) begin
            q = 64'h1;
        end
        return q[LIM_W-1:0];
    endfunction

    // ==========================================================
    // input synchroniser
    // ==========================================================
    // pins are asynchronous; two flops before anything looks at them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            din_s1 <= '0;
            din_s2 <= '0;
        end else begin
            din_s1 <= din_i;
            din_s2 <= din_s1;
        end
    end

    // ==========================================================
    // filter and detector
    // ==========================================================
    icu_filter #(
        .W(NBITS),
        .CW(LIM_W)
    ) u_filter (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .raw_i(din_s2),
        .limit_i(limit),
        .bypass_i(filt_set == `ICU_FILT_RST),
        .evt(evt.filt)
    );

    icu_detect #(
        .W(NBITS)
    ) u_detect (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .evt(evt.det)
    );

    assign evt.enable = enable;
    assign evt.edge_fall = edge_fall;
    assign evt.clr = clr_vec;

    // ==========================================================
    // bus decode
    // ==========================================================
    // one request per ack; the ack term blocks a second hit while the
    // master is still releasing the strobe
    assign wb_hit = cyc_i & stb_i & ~ack_o;
    assign wb_wr = wb_hit & we_i;
    assign wb_rd = wb_hit & ~we_i;
    assign wb_off = {adr_i[`ICU_ADR_W-1:2], 2'b00};

    // a read of a status word clears exactly the bits that word returns
    always_comb begin
        clr_vec = '0;
        if (wb_rd && wb_off == `ICU_OFF_STAT_LO) begin
            clr_vec[`ICU_LO_BITS-1:0] = '1;
        end
        if (wb_rd && wb_off == `ICU_OFF_STAT_HI) begin
            clr_vec[NBITS-1:`ICU_LO_BITS] = '1;
        end
    end

    // ack one cycle after the strobe, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= wb_hit;
        end
    end

    // ==========================================================
    // read data
    // ==========================================================
    // unmapped words read as zero; narrow high words pad with zero
    always_comb begin
        next_dat = 32'h0000_0000;
        case (wb_off)
            `ICU_OFF_IN_LO: next_dat = evt.level[31:0];
            `ICU_OFF_IN_HI: next_dat = {16'h0000, evt.level[NBITS-1:32]};
            `ICU_OFF_EN_LO: next_dat = enable[31:0];
            `ICU_OFF_EN_HI: next_dat = {16'h0000, enable[NBITS-1:32]};
            `ICU_OFF_EDGE_LO: next_dat = edge_fall[31:0];
            `ICU_OFF_EDGE_HI: next_dat = {16'h0000, edge_fall[NBITS-1:32]};
            `ICU_OFF_STAT_LO: next_dat = evt.status[31:0];
            `ICU_OFF_STAT_HI: next_dat = {16'h0000, evt.status[NBITS-1:32]};
            `ICU_OFF_FILT: next_dat = {27'h000_0000, filt_set};
            `ICU_OFF_RAW_LO: next_dat = din_s2[31:0];
            `ICU_OFF_RAW_HI: next_dat = {16'h0000, din_s2[NBITS-1:32]};
            default: next_dat = 32'h0000_0000;
        endcase
    end

    // read data is captured at the hit and held with ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (wb_rd) begin
            dat_o <= next_dat;
        end
    end

    // ==========================================================
    // enable register
    // ==========================================================
    // 1 enables a bit; reset leaves every input unable to interrupt
    always_ff @(posedge clk_i) begin
        icu_pkg::icu_word_t w;
        w = 32'h0000_0000;
        if (rst_i) begin
            enable <= `ICU_EN_RST;
        end else if (wb_wr && wb_off == `ICU_OFF_EN_LO) begin
            w = icu_merge(enable[31:0], dat_i, sel_i);
            enable[31:0] <= w;
        end else if (wb_wr && wb_off == `ICU_OFF_EN_HI) begin
            w = icu_merge({16'h0000, enable[NBITS-1:32]}, dat_i, sel_i);
            enable[NBITS-1:32] <= w[15:0];
        end
    end

    // ==========================================================
    // edge select register
    // ==========================================================
    always_ff @(posedge clk_i) begin
        icu_pkg::icu_word_t w;
        w = 32'h0000_0000;
        if (rst_i) begin
            edge_fall <= `ICU_EDGE_RST;
        end else if (wb_wr && wb_off == `ICU_OFF_EDGE_LO) begin
            w = icu_merge(edge_fall[31:0], dat_i, sel_i);
            edge_fall[31:0] <= w;
        end else if (wb_wr && wb_off == `ICU_OFF_EDGE_HI) begin
            w = icu_merge({16'h0000, edge_fall[NBITS-1:32]}, dat_i, sel_i);
            edge_fall[NBITS-1:32] <= w[15:0];
        end
    end

    // ==========================================================
    // filter setting
    // ==========================================================
    // settings above the top of the range are clamped rather than
    // letting the counter wrap into a nonsense filter time
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            filt_set <= `ICU_FILT_RST;
        end else if (wb_wr && wb_off == `ICU_OFF_FILT && sel_i[0]) begin
            if (dat_i[7:0] > 8'(`ICU_FILT_MAX)) begin
                filt_set <= `ICU_FILT_MAX;
            end else begin
                filt_set <= dat_i[`ICU_FILT_W-1:0];
            end
        end
    end

    // the division is kept off the filter path by registering its result
    assign next_limit = icu_calc_limit(filt_set);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            limit <= `ICU_LIMIT_RST;
        end else begin
            limit <= next_limit;
        end
    end

    // ==========================================================
    // interrupt request
    // ==========================================================
    // one level line for all inputs; rises one cycle after status, drops in the same cycle as a clearing read clears status
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(evt.status & ~clr_vec);
        end
    end
endmodule

// ===== icu_consts.svh
`ifndef ICU_CONSTS_SVH
`define ICU_CONSTS_SVH

// ==========================================================
// widths
// ==========================================================
`define ICU_NBITS 48
`define ICU_LO_BITS 32
`define ICU_HI_BITS 16
`define ICU_ADR_W 8
`define ICU_LIMIT_W 24

// ==========================================================
// register byte offsets
// ==========================================================
`define ICU_OFF_IN_LO 8'h00
`define ICU_OFF_IN_HI 8'h04
`define ICU_OFF_EN_LO 8'h08
`define ICU_OFF_EN_HI 8'h0C
`define ICU_OFF_EDGE_LO 8'h10
`define ICU_OFF_EDGE_HI 8'h14
`define ICU_OFF_STAT_LO 8'h18
`define ICU_OFF_STAT_HI 8'h1C
`define ICU_OFF_FILT 8'h20
`define ICU_OFF_RAW_LO 8'h24
`define ICU_OFF_RAW_HI 8'h28

// ==========================================================
// reset values
// ==========================================================
`define ICU_EN_RST 48'h0000_0000_0000
`define ICU_EDGE_RST 48'h0000_0000_0000
`define ICU_STAT_RST 48'h0000_0000_0000
`define ICU_FILT_RST 5'h00
`define ICU_LIMIT_RST 24'h00_0001

// ==========================================================
// filter setting and timing
// ==========================================================
`define ICU_FILT_MAX 5'h14
`define ICU_FILT_W 5
`define ICU_CLK_KHZ 50000
`define ICU_FILT_BASE_KHZ 8000
`define ICU_ARM_CYCLES 3'h4

`endif

// ===== icu_pkg.sv
`include "icu_consts.svh"

package icu_pkg;
    typedef logic [31:0] icu_word_t;
    typedef logic [`ICU_NBITS-1:0] icu_vec_t;
    typedef logic [`ICU_LIMIT_W-1:0] icu_limit_t;
    typedef logic [`ICU_FILT_W-1:0] icu_filt_t;
endpackage

// ===== icu_evt_if.sv
`timescale 1ns/1ps

// ==========================================================
// filtered levels, per-bit controls and status between units
// ==========================================================
interface icu_evt_if #(
    parameter int W = 48
);
    logic [W-1:0] level;
    logic [W-1:0] enable;
    logic [W-1:0] edge_fall;
    logic [W-1:0] clr;
    logic [W-1:0] status;

    modport filt (output level);
    modport det (input level, input enable, input edge_fall, input clr, output status);
    modport ctl (input level, input status, output enable, output edge_fall, output clr);
endinterface

// ===== icu_filter.sv
`timescale 1ns/1ps

// ==========================================================
// per-bit stability filter
// ==========================================================
module icu_filter #(
    parameter int W = 48,
    parameter int CW = 24
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] raw_i,
    input wire logic [CW-1:0] limit_i,
    input wire logic bypass_i,
    icu_evt_if.filt evt
);
    wire logic [W-1:0] state;

    // a bypassed filter still tracks the raw level so enabling it never glitches
    assign evt.level = bypass_i ? raw_i : state;

    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            logic [CW-1:0] cnt;
            logic st;
            // each bit keeps its own flop so no two processes share one vector
            assign state[i] = st;
            // level is accepted only after staying different for limit_i cycles
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    st <= 1'b0;
                    cnt <= '0;
                end else if (bypass_i || raw_i[i] == st) begin
                    st <= raw_i[i];
                    cnt <= '0;
                end else if (cnt >= limit_i - CW'(1)) begin
                    st <= raw_i[i];
                    cnt <= '0;
                end else begin
                    cnt <= cnt + CW'(1);
                end
            end
        end
    endgenerate
endmodule

// ===== icu_detect.sv
`timescale 1ns/1ps
`include "icu_consts.svh"

// ==========================================================
// per-bit edge detection and sticky status
// ==========================================================
module icu_detect #(
    parameter int W = 48
) (
    input wire logic clk_i,
    input wire logic rst_i,
    icu_evt_if.det evt
);
    logic [W-1:0] prev;
    logic [W-1:0] stat;
    logic [W-1:0] fire;
    logic [2:0] arm_cnt;
    logic armed;

    assign evt.status = stat;
    assign armed = (arm_cnt == `ICU_ARM_CYCLES);

    // edge select 0 fires on value 0->1, 1 fires on value 1->0
    assign fire = {W{armed}} & evt.enable
        & ((~evt.edge_fall & evt.level & ~prev)
        | (evt.edge_fall & ~evt.level & prev));

    // hold off detection until the input pipeline has settled after reset,
    // otherwise a high input would look like a fresh rising edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            arm_cnt <= 3'h0;
        end else if (!armed) begin
            arm_cnt <= arm_cnt + 3'h1;
        end
    end

    // previous level of every bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev <= '0;
        end else begin
            prev <= evt.level;
        end
    end

    // sticky status: a new event wins over a clearing read in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat <= W'(`ICU_STAT_RST);
        end else begin
            stat <= (stat & ~evt.clr) | fire;
        end
    end
endmodule

// ===== icu_top_sva.sv
`timescale 1ns/1ps

// ==========================================================
// port checker for the input change interrupt unit
// ==========================================================
module icu_top_sva #(
    parameter int NBITS = 48
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic [NBITS-1:0] din_i,
    input wire logic irq_o
);
    // one clock domain, so defaults keep each property short
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_reset_quiet: assert property ($fell(rst_i) |-> !ack_o && !irq_o)
        else $error("ack or irq high after reset");
    a_ack_one_cycle: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_ack_follows_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not acked in one cycle");
    a_ack_needs_req: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    a_ack_idle_low: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack while bus idle");
    // read data only moves with a read answer, so software never sees it shift
    a_dat_hold: assert property ($changed(dat_o) |-> ack_o && !we_i)
        else $error("read data changed outside a read");
    // the request only drops together with the answer to a status read
    a_irq_drop_read: assert property ($fell(irq_o) |-> ack_o && !we_i)
        else $error("irq dropped without a read");
    a_unmapped_zero: assert property (cyc_i && stb_i && !we_i && !ack_o && adr_i[7:2] > 6'hA
        |=> dat_o == 32'h0)
        else $error("unmapped read not zero");
endmodule

bind icu_top icu_top_sva #(.NBITS(NBITS)) u_icu_top_sva (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .din_i(din_i), .irq_o(irq_o));

// ===== icu_host_model.sv
`timescale 1ns/1ps

// ==========================================================
// host interrupt input: counts each new request
// ==========================================================
module icu_host_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic irq_i,
    output logic [7:0] req_cnt_o
);
    logic irq_q;

    // level input, so only a rise is a new request; a stuck line counts once
    always_ff @(posedge clk_i) begin
        irq_q <= rst_i ? 1'b0 : irq_i;
        if (rst_i) begin
            req_cnt_o <= 8'h00;
        end else if (irq_i && !irq_q) begin
            req_cnt_o <= req_cnt_o + 8'h01;
        end
    end
endmodule

// ===== tb.sv
`timescale 1ns/1ps
`include "icu_consts.svh"

// ==========================================================
// bench for the input change interrupt unit
// ==========================================================
module tb;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o;
    logic [7:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o;
    logic [47:0] din_i;
    logic [7:0] host_cnt;
    int fails, n_checks;

    icu_top u_icu_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .din_i(din_i), .irq_o(irq_o));
    icu_host_model u_icu_host_model (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq_o),
        .req_cnt_o(host_cnt));

    // 50 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task wrap_up;
        if (fails == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task check(input logic [47:0] seen, input logic [47:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, seen, exp);
        end
    endtask

    // one classic cycle; held until ack is sampled, then one idle cycle
    task bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        int k;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 20);
        if (ack_o !== 1'b1) begin
            fails++;
            wrap_up();
        end
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0000_0000, q);
        check({16'h0000, q}, {16'h0000, exp});
    endtask

    task idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // new pin levels, then a wait of n cycles, which the caller picks
    task pins(input logic [47:0] v, input int n);
        din_i <= v;
        idle(n);
    endtask

    initial begin
        rst_i = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = 8'h00;
        sel_i = 4'hF;
        dat_i = 32'h0000_0000;
        din_i = 48'h0000_0000_0000;
        fails = 0;
        n_checks = 0;
        idle(2);
        rst_i <= 1'b0;
        idle(6);
        // reset values of enable, edge select, status and filter setting
        for (int a = 8; a <= 28; a += 4) rd_chk(8'(a), 32'h0000_0000);
        rd_chk(`ICU_OFF_FILT, 32'h0000_0000);
        rd_chk(8'h30, 32'h0000_0000);
        // all pins rise while masked: inputs seen, nothing recorded
        pins(48'hFFFF_FFFF_FFFF, 10);
        rd_chk(`ICU_OFF_IN_LO, 32'hFFFF_FFFF);
        rd_chk(`ICU_OFF_IN_HI, 32'h0000_FFFF);
        rd_chk(`ICU_OFF_STAT_LO, 32'h0000_0000);
        rd_chk(`ICU_OFF_STAT_HI, 32'h0000_0000);
        check({47'h0, irq_o}, 48'h0);
        pins(48'h0000_0000_0000, 10);
        // enable every bit; rising edges on the lowest and highest pin
        wr(`ICU_OFF_EN_LO, 32'hFFFF_FFFF);
        wr(`ICU_OFF_EN_HI, 32'hFFFF_FFFF);
        rd_chk(`ICU_OFF_EN_HI, 32'h0000_FFFF);
        pins(48'h8000_0000_0001, 8);
        check({47'h0, irq_o}, 48'h1);
        rd_chk(`ICU_OFF_STAT_LO, 32'h0000_0001);
        idle(3);
        check({47'h0, irq_o}, 48'h1);
        rd_chk(`ICU_OFF_STAT_LO, 32'h0000_0000);
        rd_chk(`ICU_OFF_STAT_HI, 32'h0000_8000);
        idle(3);
        check({47'h0, irq_o}, 48'h0);
        pins(48'h0000_0000_0000, 8);
        rd_chk(`ICU_OFF_STAT_LO, 32'h0000_0000);
        // edge select 1 on the low word: fires on falls only
        wr(`ICU_OFF_EDGE_LO, 32'hFFFF_FFFF);
        rd_chk(`ICU_OFF_EDGE_LO, 32'hFFFF_FFFF);
        // only lane 0 of the high edge word may change
        sel_i <= 4'h1;
        wr(`ICU_OFF_EDGE_HI, 32'hFFFF_FFFF);
        sel_i <= 4'hF;
        rd_chk(`ICU_OFF_EDGE_HI, 32'h0000_00FF);
        wr(`ICU_OFF_EDGE_HI, 32'h0000_0000);
        pins(48'h0000_0000_0001, 8);
        rd_chk(`ICU_OFF_STAT_LO, 32'h0000_0000);
        pins(48'h0000_0000_0000, 8);
        rd_chk(`ICU_OFF_STAT_LO, 32'h0000_0001);
        wr(`ICU_OFF_EDGE_LO, 32'h0000_0000);
        // filter setting clamps at 20; at 3 a pin must hold 50 cycles
        wr(`ICU_OFF_FILT, 32'h0000_001F);
        rd_chk(`ICU_OFF_FILT, 32'h0000_0014);
        wr(`ICU_OFF_FILT, 32'h0000_0003);
        pins(48'h0000_0000_0001, 10);
        pins(48'h0000_0000_0000, 80);
        rd_chk(`ICU_OFF_STAT_LO, 32'h0000_0000);
        pins(48'h0000_0000_0001, 80);
        rd_chk(`ICU_OFF_STAT_LO, 32'h0000_0001);
        // bypass again; a rise landing in the read cycle is kept for the next read
        wr(`ICU_OFF_FILT, 32'h0000_0000);
        pins(48'h0000_0000_0003, 2);
        rd_chk(`ICU_OFF_STAT_LO, 32'h0000_0000);
        rd_chk(`ICU_OFF_STAT_LO, 32'h0000_0002);
        rd_chk(`ICU_OFF_RAW_LO, 32'h0000_0003);
        rd_chk(`ICU_OFF_RAW_HI, 32'h0000_0000);
        idle(4);
        check({40'h0, host_cnt}, 48'h4);
        // mid-run reset with pins high: controls and status return to reset values
        rst_i <= 1'b1;
        idle(2);
        rst_i <= 1'b0;
        idle(6);
        rd_chk(`ICU_OFF_EN_LO, 32'h0000_0000);
        rd_chk(`ICU_OFF_EDGE_LO, 32'h0000_0000);
        rd_chk(`ICU_OFF_STAT_LO, 32'h0000_0000);
        rd_chk(`ICU_OFF_FILT, 32'h0000_0000);
        check({47'h0, irq_o}, 48'h0);
        wrap_up();
    end
endmodule
